// File: bench/scs_clock_ctrl_sva.sv
// assertion checker for the switching clock control block
`timescale 1ns/1ns
module scs_clock_ctrl_sva (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ext_ref_clock_pin,
    input wire logic sw_clk,
    input wire logic pll_enable,
    input wire logic pll_src_ext,
    input wire logic spread_active,
    input wire logic ref_fault_status,
    input wire logic ref_clock_out_pin
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_ext_settled;
        pll_src_ext && $past(pll_src_ext) && $past(pll_src_ext, 2);
    endsequence
    sequence s_int_settled;
        !pll_src_ext && !$past(pll_src_ext);
    endsequence
    property p_spread_sync; pll_enable |-> !spread_active; endproperty
    property p_pll_src; pll_src_ext |-> pll_enable; endproperty
    property p_fault_nopll; !pll_enable |-> !ref_fault_status; endproperty
    // two cycles allowed for the flag to settle first
    property p_fallback; ref_fault_status [*2] |=> !pll_src_ext; endproperty
    property p_return; $rose(pll_src_ext) |-> !ref_fault_status; endproperty
    property p_ext_follow;
        s_ext_settled |-> sw_clk == $past(ext_ref_clock_pin, 2);
    endproperty
    property p_ref_out; ref_clock_out_pin |-> $past(sw_clk); endproperty
    property p_toggle; s_int_settled |-> ##[1:30] $changed(sw_clk); endproperty
    property p_pll_steady; pll_enable |=> pll_enable; endproperty
    a_spread_sync: assert property (p_spread_sync)
        else $error("spread active with sync on");
    a_pll_src: assert property (p_pll_src)
        else $error("external source without pll");
    a_fault_nopll: assert property (p_fault_nopll)
        else $error("fault status with sync off");
    a_fallback: assert property (p_fallback)
        else $error("no fallback on bad reference");
    a_return: assert property (p_return)
        else $error("return to external while invalid");
    a_ext_follow: assert property (p_ext_follow)
        else $error("switching clock not following reference");
    a_ref_out: assert property (p_ref_out)
        else $error("reference output not tracking switching clock");
    a_toggle: assert property (p_toggle)
        else $error("internal switching clock stalled");
    a_pll_steady: assert property (p_pll_steady)
        else $error("pll stopped while sync enabled");
endmodule
bind scs_clock_ctrl scs_clock_ctrl_sva u_sva (
    .clock(clock), .nrst(nrst), .ext_ref_clock_pin(ext_ref_clock_pin),
    .sw_clk(sw_clk), .pll_enable(pll_enable), .pll_src_ext(pll_src_ext),
    .spread_active(spread_active), .ref_fault_status(ref_fault_status),
    .ref_clock_out_pin(ref_clock_out_pin)
);

// File: bench/scs_ref_src.sv
// external reference clock source model
`timescale 1ns/1ns
module scs_ref_src (
    input  wire logic       clock,
    input  wire logic       run,
    input  wire logic [9:0] period,
    output logic            ref_pin
);
    logic [9:0] cnt;
    initial begin
        cnt = 10'h000;
        ref_pin = 1'b0;
    end
    always @(posedge clock) begin
        if (!run || cnt + 10'h001 >= period) begin
            cnt <= 10'h000;
        end else begin
            cnt <= cnt + 10'h001;
        end
        // high for half the period, duty near fifty
        // idle source held low, the pin pulls down anyway
        ref_pin <= run && (cnt < period / 2);
    end
endmodule

// File: bench/tb_top.sv
// self-checking testbench for the switching clock control block
`timescale 1ns/1ns
module tb_top;
    logic        clock, nrst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  dflt;
    logic        sys_on, ref_pin, run, sw_clk, pll_enable, pll_src_ext;
    logic        spread_active, ref_fault_status, irq_out_n, ref_out, prev;
    logic        err;
    logic [9:0]  period;
    logic [9:0]  per_t [8] = '{10'h022, 10'h021, 10'h032, 10'h033,
                               10'h0c8, 10'h0c7, 10'h12c, 10'h12d};
    int          n_fail, num_checks, n, i, hp_min, hp_max;
    // nominal half period of the internal switching clock in cycles
    localparam int HALF_SW = scs_pkg::SW_DIV / 2 * scs_pkg::CLK_KHZ
                             / scs_pkg::HF_KHZ;
    localparam int HP_WLO = HALF_SW * 100 / (100 + scs_pkg::SS_WIDE_PCT);
    localparam int HP_WHI = HALF_SW * 100 / (100 - scs_pkg::SS_WIDE_PCT);
    localparam int HP_NLO = HALF_SW * 100 / (100 + scs_pkg::SS_NARROW_PCT);
    localparam int HP_NHI = HALF_SW * 100 / (100 - scs_pkg::SS_NARROW_PCT);
    scs_clock_ctrl #(.DEB_N(2)) uut (
        .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .spread_enable_default(dflt[0]), .spread_range_default(dflt[1]),
        .ref_range_default(dflt[2]), .ref_out_enable_default(dflt[3]),
        .ext_ref_enable_default(dflt[4]), .sys_on(sys_on),
        .ext_ref_clock_pin(ref_pin), .sw_clk(sw_clk),
        .pll_enable(pll_enable), .pll_src_ext(pll_src_ext),
        .spread_active(spread_active), .ref_fault_status(ref_fault_status),
        .irq_out_n(irq_out_n), .ref_clock_out_pin(ref_out)
    );
    scs_ref_src ref_src (.clock(clock), .run(run), .period(period),
                         .ref_pin(ref_pin));
    always #5 clock = ~clock;
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task give_up;
        n_fail++;
        complete_run();
    endtask
    task chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) give_up();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task do_reset(input logic [4:0] d);
        @(posedge clock);
        nrst <= 1'b0;
        dflt <= d;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
    endtask
    // bounded wait on the fault status or on the source select
    task wait_for(input logic sel, input logic v);
        int k;
        k = 0;
        while ((sel ? pll_src_ext : ref_fault_status) !== v && k < 5000) begin
            @(posedge clock);
            k++;
        end
        if ((sel ? pll_src_ext : ref_fault_status) !== v) give_up();
    endtask
    task count_out;
        n = 0;
        prev = ref_out;
        repeat (200) begin
            @(posedge clock);
            if (ref_out !== prev) n++;
            prev = ref_out;
        end
    endtask
    // shortest and longest half period of the switching clock
    task measure_hp(input int cycles);
        int len;
        len = -1;
        hp_min = 1000;
        hp_max = 0;
        prev = sw_clk;
        repeat (cycles) begin
            @(posedge clock);
            if (len >= 0) len++;
            if (sw_clk !== prev) begin
                if (len > 0 && len < hp_min) hp_min = len;
                if (len > hp_max) hp_max = len;
                len = 0;
            end
            prev = sw_clk;
        end
    endtask
    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        {psel, penable, pwrite, sys_on, run} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        dflt = 5'h00;
        period = 10'h028;
        n_fail = 0;
        num_checks = 0;
        do_reset(5'h00);
        apb(1'b0, 8'h00, 32'h0);
        chk_word(rd, 32'h0);
        chk_bit(pll_enable, 1'b0);
        apb(1'b1, 8'h00, 32'h3);
        chk_bit(spread_active, 1'b1);
        measure_hp(4200);
        chk_bit(hp_min >= HP_WLO && hp_min < HALF_SW, 1'b1);
        chk_bit(hp_max > HALF_SW && hp_max <= HP_WHI + 1, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk_word(rd, 32'h3);
        apb(1'b1, 8'h00, 32'h1);
        measure_hp(4200);
        chk_bit(hp_min >= HP_NLO && hp_min < HALF_SW, 1'b1);
        chk_bit(hp_max > HALF_SW && hp_max <= HP_NHI + 1, 1'b1);
        apb(1'b1, 8'h00, 32'h8);
        apb(1'b0, 8'h00, 32'h0);
        chk_word(rd, 32'h0);
        chk_bit(spread_active, 1'b0);
        sys_on <= 1'b1;
        apb(1'b1, 8'h00, 32'h8);
        count_out();
        chk_bit(n >= 200 / HALF_SW - 1 && n <= 200 / HALF_SW + 1,
                1'b1);
        apb(1'b1, 8'h00, 32'h0);
        count_out();
        chk_word(32'(n), 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk_bit(err, 1'b1);
        chk_word(rd, 32'h0);
        $display("test sync_off done");
        do_reset(5'h1b);
        repeat (4) @(posedge clock);
        chk_bit(irq_out_n, 1'b0);
        chk_bit(ref_fault_status, 1'b1);
        chk_bit(spread_active, 1'b0);
        chk_bit(pll_enable, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk_word(rd, 32'hb);
        apb(1'b1, 8'h0c, 32'h1);
        chk_bit(irq_out_n, 1'b1);
        apb(1'b1, 8'h0c, 32'h0);
        run <= 1'b1;
        wait_for(1'b0, 1'b0);
        chk_bit(ref_fault_status, 1'b0);
        repeat (100) @(posedge clock);
        chk_bit(pll_src_ext, 1'b0);
        apb(1'b0, 8'h04, 32'h0);
        chk_bit(rd[0], 1'b0);
        apb(1'b1, 8'h08, 32'h1);
        wait_for(1'b1, 1'b1);
        chk_bit(irq_out_n, 1'b1);
        for (i = 0; i < 8; i++) begin
            if (i == 4) apb(1'b1, 8'h00, 32'hf);
            period <= per_t[i];
            wait_for(1'b0, i[0]);
            chk_bit(ref_fault_status, i[0]);
            repeat (3) @(posedge clock);
            if (i[0]) chk_bit(pll_src_ext, 1'b0);
        end
        $display("test sync_on done");
        complete_run();
    end
endmodule

// File: rtl/scs_clock_ctrl.sv
// switching clock control: spread spectrum, reference sync, fault fallback
// Contract
// (RULE1) spread enable modulates the internal clock
// (RULE2) spread enable loads its default at power-up
// (RULE3) range bit limits deviation to 5/10 percent
// (RULE4) range select loads its default at power-up
// (RULE5) sweep at 24 kHz on internal clock
// (RULE6) sync enabled forces spread off
// (RULE7) host keeps regulators in PWM mode
// (RULE8) sync default 0: PLL off, internal only
// (RULE9) sync default 1: PLL always running
// (RULE10) unused reference input held low externally
// (RULE11) valid windows 2000-3000 or 333-500 kHz
// (RULE12) outside the chosen window is invalid
// (RULE13) reference range loads its default at power-up
// (RULE14) source keeps duty between 40 and 60
// (RULE15) bad reference: fall back, flag, interrupt
// (RULE16) fault status follows reference validity
// (RULE17) return only when flag clear and valid
// (RULE18) host checks status, clears or goes safe
// (RULE19) enabled reference output toggles at base frequency
// (RULE20) disabled reference output held low
// (RULE21) output enable writable when system on
// (RULE22) internal clock divided by 8
// (RULE23) validity decision debounced before switching
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ns
module scs_clock_ctrl #(
    parameter int DEB_N = 4
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        spread_enable_default,
    input  wire logic        spread_range_default,
    input  wire logic        ext_ref_enable_default,
    input  wire logic        ref_range_default,
    input  wire logic        ref_out_enable_default,
    input  wire logic        sys_on,
    input  wire logic        ext_ref_clock_pin,
    output logic             sw_clk,
    output logic             pll_enable,
    output logic             pll_src_ext,
    output logic             spread_active,
    output logic             ref_fault_status,
    output logic             irq_out_n,
    output logic             ref_clock_out_pin
);
    generate
        if (DEB_N < 1 || DEB_N > 255) begin : g_bad_deb
            $error("DEB_N must lie in 1..255");
        end
    endgenerate

    scs_pkg::scs_ctrl_s ctrl_reg;
    logic                   sync_en_reg;
    logic                   mask_reg;
    logic                   flag_reg;
    logic                   flag_next;
    scs_pkg::scs_src_e      src_reg;
    scs_pkg::scs_src_e      src_next;
    logic signed [11:0]     tri_reg;
    logic                   dir_reg;
    logic [scs_pkg::ACC_W-1:0] acc_reg;
    logic [2:0]             div_reg;
    logic                   ref_d_reg;
    logic [scs_pkg::PER_W-1:0] per_reg;
    logic                   first_reg;
    logic                   valid_reg;
    logic [7:0]             deb_reg;
    logic [31:0]            prdata_reg;
    logic                   irq_reg;
    logic                   sw_reg;
    logic                   out_reg;

    // inclusive window test on a measured period
    function automatic logic in_window(
        input logic [scs_pkg::PER_W-1:0] per,
        input logic [scs_pkg::PER_W-1:0] lo,
        input logic [scs_pkg::PER_W-1:0] hi
    );
        return (per >= lo) && (per <= hi);
    endfunction

    // bus decode
    wire logic wr_acc   = psel & penable & pwrite;
    wire logic setup    = psel & ~penable;
    wire logic hit_ctrl = paddr == scs_pkg::OFS_CTRL;
    wire logic hit_stat = paddr == scs_pkg::OFS_STATUS;
    wire logic hit_irq  = paddr == scs_pkg::OFS_IRQ;
    wire logic hit_mask = paddr == scs_pkg::OFS_MASK;
    wire logic mapped   = hit_ctrl | hit_stat | hit_irq | hit_mask;
    wire logic fault_clr = wr_acc & hit_irq & pwdata[scs_pkg::BIT_FAULT_FLAG];

    // spread control
    wire logic spread_on = ctrl_reg.spread_enable & ~sync_en_reg; // see (RULE6)
    wire logic signed [11:0] amp = ctrl_reg.spread_range_select
        ? 12'(scs_pkg::AMP_WIDE) : 12'(scs_pkg::AMP_NARROW); // see (RULE3)
    wire logic signed [23:0] prod = tri_reg * amp;
    wire logic signed [15:0] offs = 16'(prod >>> scs_pkg::TRI_SH);
    wire logic [scs_pkg::ACC_W-1:0] inc =
        scs_pkg::ACC_W'(scs_pkg::HF_INC) + offs; // see (RULE1)
    wire logic [scs_pkg::ACC_W:0] acc_sum = {1'b0, acc_reg} + {1'b0, inc};
    wire logic hf_tick = acc_sum[scs_pkg::ACC_W];
    wire logic int_clk = div_reg[2]; // see (RULE22)
    wire logic tri_top = tri_reg >= 12'(scs_pkg::TRI_MAX);
    wire logic tri_bot = tri_reg <= -12'(scs_pkg::TRI_MAX);

    // reference period check
    wire logic ref_rise = ext_ref_clock_pin & ~ref_d_reg;
    wire logic [scs_pkg::PER_W-1:0] per_min = ctrl_reg.ref_range_select
        ? scs_pkg::PER_W'(scs_pkg::PER1_MIN)
        : scs_pkg::PER_W'(scs_pkg::PER0_MIN);
    wire logic [scs_pkg::PER_W-1:0] per_max = ctrl_reg.ref_range_select
        ? scs_pkg::PER_W'(scs_pkg::PER1_MAX)
        : scs_pkg::PER_W'(scs_pkg::PER0_MAX);
    wire logic timeout = per_reg > per_max;
    // counter starts at zero, so the edge spacing is one more
    wire logic [scs_pkg::PER_W-1:0] per_len = per_reg + 1'b1;
    wire logic per_ok  = in_window(per_len, per_min, per_max); // see (RULE11)
    // a verdict on each counted edge, and one per missing period
    wire logic verdict    = (ref_rise & ~first_reg) | timeout;
    wire logic verdict_ok = ref_rise & ~first_reg & per_ok
        & ~timeout; // see (RULE12)
    wire logic disagree   = verdict & (verdict_ok != valid_reg);
    wire logic [7:0] deb_inc = deb_reg + 8'h01;

    // source selection
    always_comb begin
        src_next = src_reg;
        case (src_reg)
            scs_pkg::SRC_INT: begin
                if (sync_en_reg & valid_reg & ~flag_reg) begin
                    src_next = scs_pkg::SRC_EXT; // see (RULE17)
                end
            end
            scs_pkg::SRC_EXT: begin
                if (~sync_en_reg | ~valid_reg) begin
                    src_next = scs_pkg::SRC_INT; // see (RULE15)
                end
            end
            default: src_next = scs_pkg::SRC_INT;
        endcase
    end

    // a fault arriving with the clear keeps the flag set
    assign flag_next = (flag_reg & ~fault_clr)
        | (sync_en_reg & ~valid_reg); // see (RULE15)

    // registers
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_reg.spread_enable <= spread_enable_default; // see (RULE2)
            ctrl_reg.spread_range_select <=
                spread_range_default; // see (RULE4)
            ctrl_reg.ref_range_select <= ref_range_default; // see (RULE13)
            ctrl_reg.ref_out_enable <=
                ref_out_enable_default; // see (RULE21)
            sync_en_reg <= ext_ref_enable_default;
            mask_reg    <= scs_pkg::MASK_RESET;
        end else if (wr_acc & hit_ctrl) begin
            ctrl_reg.spread_enable <= pwdata[scs_pkg::BIT_SPREAD_EN];
            ctrl_reg.spread_range_select <=
                pwdata[scs_pkg::BIT_SPREAD_RANGE];
            ctrl_reg.ref_range_select <= pwdata[scs_pkg::BIT_REF_RANGE];
            if (sys_on) begin
                ctrl_reg.ref_out_enable <=
                    pwdata[scs_pkg::BIT_REF_OUT_EN]; // see (RULE21)
            end
        end else if (wr_acc & hit_mask) begin
            mask_reg <= pwdata[scs_pkg::BIT_FAULT_FLAG];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            flag_reg <= 1'b0;
            src_reg  <= scs_pkg::SRC_INT;
            irq_reg  <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            src_reg  <= src_next;
            irq_reg  <= flag_next & ~mask_reg; // see (RULE15)
        end
    end

    // triangle sweep, one full period per modulation cycle
    // restarts at zero when enabled, so the sweep stays centred
    always_ff @(posedge clock) begin
        if (!nrst || !spread_on) begin
            tri_reg <= 12'sh000;
            dir_reg <= 1'b1;
        end else begin
            if (dir_reg & tri_top) begin
                dir_reg <= 1'b0;
            end else if (!dir_reg & tri_bot) begin
                dir_reg <= 1'b1;
            end
            tri_reg <= (dir_reg & ~tri_top) | (~dir_reg & tri_bot)
                ? tri_reg + 12'sh001 : tri_reg - 12'sh001; // see (RULE5)
        end
    end

    // internal high-frequency clock and divide-by-8
    always_ff @(posedge clock) begin
        if (!nrst) begin
            acc_reg <= '0;
            div_reg <= 3'h0;
        end else begin
            acc_reg <= acc_sum[scs_pkg::ACC_W-1:0];
            if (hf_tick) begin
                div_reg <= div_reg + 3'h1; // see (RULE22)
            end
        end
    end

    // reference period measurement
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ref_d_reg <= 1'b0;
            per_reg   <= '0;
            first_reg <= 1'b1;
        end else begin
            ref_d_reg <= ext_ref_clock_pin;
            if (timeout) begin
                per_reg   <= '0;
                first_reg <= 1'b1; // next edge only restarts timing
            end else if (ref_rise) begin
                per_reg   <= '0;
                first_reg <= 1'b0;
            end else begin
                per_reg <= per_len;
            end
        end
    end

    // fewer than DEB_N disagreeing verdicts in a row cannot flip validity
    always_ff @(posedge clock) begin
        if (!nrst) begin
            valid_reg <= 1'b0;
            deb_reg   <= 8'h00;
        end else if (verdict & ~disagree) begin
            deb_reg <= 8'h00;
        end else if (disagree) begin
            if (deb_inc >= 8'(DEB_N)) begin
                valid_reg <= verdict_ok; // see (RULE23)
                deb_reg   <= 8'h00;
            end else begin
                deb_reg <= deb_inc;
            end
        end
    end

    // switching clock and reference output
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sw_reg  <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            sw_reg  <= (src_reg == scs_pkg::SRC_EXT) ? ref_d_reg : int_clk;
            // disabled output sits low, like the pulled-down pin
            out_reg <= ctrl_reg.ref_out_enable
                & sw_reg; // see (RULE19) (RULE20)
        end
    end

    // read data captured in setup so it comes from a flop
    wire logic [31:0] status_word = 32'({
        sync_en_reg,
        spread_on,
        sync_en_reg,
        src_reg == scs_pkg::SRC_EXT,
        ~valid_reg & sync_en_reg
    });
    wire logic [31:0] rd_mux =
        hit_ctrl ? 32'(ctrl_reg) :
        hit_stat ? status_word :
        hit_irq  ? 32'(flag_reg) :
        hit_mask ? 32'(mask_reg) : 32'h0000_0000;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup) begin
            prdata_reg <= rd_mux;
        end
    end

    assign prdata  = prdata_reg;
    // zero wait states: every register answers in the access cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign sw_clk  = sw_reg;
    assign pll_enable  = sync_en_reg; // see (RULE8) (RULE9)
    assign pll_src_ext = src_reg == scs_pkg::SRC_EXT;
    assign spread_active = spread_on; // see (RULE1)
    assign ref_fault_status = ~valid_reg & sync_en_reg; // see (RULE16)
    assign irq_out_n = ~irq_reg;
    assign ref_clock_out_pin = out_reg;
endmodule

// File: shared/scs_pkg.sv
// constants and carrier types for the switching clock control block
package scs_pkg;
    // clock and timing
    localparam int CLK_KHZ  = 100000;
    localparam int HF_KHZ   = 20000;
    localparam int ACC_W    = 16;
    localparam int HF_INC   = HF_KHZ * 65536 / CLK_KHZ;
    localparam int SW_DIV   = 8;
    localparam int MOD_KHZ  = 24;
    localparam int MOD_CYC  = CLK_KHZ / MOD_KHZ;
    localparam int TRI_MAX  = MOD_CYC / 4;
    localparam int TRI_SH   = 10;
    localparam int SS_NARROW_PCT = 5;
    localparam int SS_WIDE_PCT   = 10;
    // amplitudes rounded down so the peak never exceeds the range
    localparam int AMP_NARROW =
        HF_INC * SS_NARROW_PCT / 100 * (1 << TRI_SH) / TRI_MAX;
    localparam int AMP_WIDE =
        HF_INC * SS_WIDE_PCT / 100 * (1 << TRI_SH) / TRI_MAX;
    // accepted reference windows in kHz
    localparam int REF0_MIN_KHZ = 2000;
    localparam int REF0_MAX_KHZ = 3000;
    localparam int REF1_MIN_KHZ = 333;
    localparam int REF1_MAX_KHZ = 500;
    localparam int PER_W        = 9;
    // shortest period rounded up, longest down: no edge case slips in
    localparam int PER0_MIN = (CLK_KHZ + REF0_MAX_KHZ - 1) / REF0_MAX_KHZ;
    localparam int PER0_MAX = CLK_KHZ / REF0_MIN_KHZ;
    localparam int PER1_MIN = (CLK_KHZ + REF1_MAX_KHZ - 1) / REF1_MAX_KHZ;
    localparam int PER1_MAX = CLK_KHZ / REF1_MIN_KHZ;
    // register map
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ    = 8'h08;
    localparam logic [7:0] OFS_MASK   = 8'h0c;
    localparam int BIT_SPREAD_EN    = 0;
    localparam int BIT_SPREAD_RANGE = 1;
    localparam int BIT_REF_RANGE    = 2;
    localparam int BIT_REF_OUT_EN   = 3;
    localparam int BIT_ST_FAULT     = 0;
    localparam int BIT_ST_EXT       = 1;
    localparam int BIT_ST_PLL       = 2;
    localparam int BIT_ST_SPREAD    = 3;
    localparam int BIT_ST_SYNC_EN   = 4;
    localparam int BIT_FAULT_FLAG   = 0;
    localparam logic MASK_RESET     = 1'b0;

    typedef struct packed {
        logic ref_out_enable;
        logic ref_range_select;
        logic spread_range_select;
        logic spread_enable;
    } scs_ctrl_s;

    typedef enum logic [0:0] {
        SRC_INT = 1'b0,
        SRC_EXT = 1'b1
    } scs_src_e;
endpackage
